// [rtl/fhs_pkg.sv]
/*
  Package for the fault hiccup sequencer: constants, state encoding and carriers.
  Assumes a single 200 MHz clock domain and synchronous comparator inputs.
*/
package fhs_pkg;

  // ----------------------------------------------------------------
  // Timing and counts
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam int unsigned SW_FREQ_KHZ     = 1000;
  localparam int unsigned SW_PERIOD_PS    = 1000000000 / SW_FREQ_KHZ;
  localparam int unsigned SW_DIV_CYCLES   = SW_PERIOD_PS / CLK_PERIOD_PS;
  localparam int unsigned FAULT_OVF_COUNT = 3;
  localparam int unsigned DISCHARGE_SW    = 256;
  localparam int unsigned OC_STEP_AMPS    = 2;
  localparam int unsigned SS_DEF_SW       = 2000;
  localparam logic [1:0]  CNT_RST         = 2'h0;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FHS_OFF       = 3'b000,
    FHS_DISCHARGE = 3'b001,
    FHS_SOFTSTART = 3'b010,
    FHS_RUN       = 3'b011,
    FHS_COOL      = 3'b100
  } fhs_state_t;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       uv_trip;
    logic       uv_recover;
    logic [4:0] oc_sample;
  } fhs_sense_t;

  typedef struct packed {
    logic switch_en;
    logic ss_charge;
    logic ss_discharge;
    logic output_valid_flag;
    logic shutdown_pulse;
  } fhs_ctrl_t;

endpackage : fhs_pkg

// [rtl/fhs_tick_gen.sv]
/*
  Switching tick generator: internal 1 MHz divider or rising edges of a
  synchronised external clock.
  Assumes sync_clk_i is already synchronous to clk_i.
*/
`timescale 1ns/10ps
module fhs_tick_gen #(
  parameter int unsigned DIV = fhs_pkg::SW_DIV_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic ext_sync_i,
  input  wire logic sync_clk_i,
  output logic      tick_o
);
  import fhs_pkg::*;

  typedef struct packed {
    logic [15:0] div_reg;
    logic        sync_d_reg;
    logic        tick_reg;
  } fhs_tick_st_t;

  fhs_tick_st_t st_reg;
  fhs_tick_st_t st_next;

  // ----------------------------------------------------------------
  // Tick selection
  // ----------------------------------------------------------------
  always_comb begin
    st_next            = st_reg;
    st_next.sync_d_reg = sync_clk_i;
    if (ext_sync_i) begin
      st_next.div_reg  = 16'h0000;
      st_next.tick_reg = sync_clk_i & ~st_reg.sync_d_reg;
    end else if (st_reg.div_reg == 16'(DIV - 1)) begin
      st_next.div_reg  = 16'h0000;
      st_next.tick_reg = 1'b1;
    end else begin
      st_next.div_reg  = st_reg.div_reg + 16'h0001;
      st_next.tick_reg = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick_o = st_reg.tick_reg;

  a_tick_spacing: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!ext_sync_i && tick_o) |=> !tick_o) else $error("Tick lasted over one cycle.");

endmodule : fhs_tick_gen

// [rtl/fhs_sequencer.sv]
/*
  Fault hiccup sequencer: undervoltage and overcurrent counters, shutdown,
  cool-down delay, soft-start restart and output valid flag.
  Assumes comparator inputs are synchronous to clk_i and sampled per tick.
*/
// Operation
// - Count undervoltage comparator trips per tick.
// - Clear undervoltage counter on recovery.
// - Three undervoltage counts shut regulator down.
// - Hold off for soft-start length after shutdown.
// - Clear undervoltage counter entering delay.
// - Start soft-start when delay expires.
// - Successful soft-start raises valid flag, runs.
// - Undervoltage hiccup repeats until start-up succeeds.
// - Sample switch current once per switching cycle.
// - Overcurrent limit grows 2A per block.
// - Each over-limit sample adds exactly one.
// - Overcurrent count of three shuts down.
// - Below-limit sample clears overcurrent counter.
// - Clear overcurrent counter entering delay.
// - Overcurrent hiccup repeats until start-up succeeds.
// - Tick from 1 MHz oscillator or sync.
// - Discharge soft-start for 256 clock cycles.
// - Enable low drops valid flag immediately.
`timescale 1ns/10ps
module fhs_sequencer #(
  parameter int unsigned SS_CYCLES  = fhs_pkg::SS_DEF_SW,
  parameter int unsigned DIS_CYCLES = fhs_pkg::DISCHARGE_SW,
  parameter int unsigned DIV        = fhs_pkg::SW_DIV_CYCLES
) (
  input  wire logic               clk_i,
  input  wire logic               rstn_i,
  input  wire logic               enable_i,
  input  wire logic               supply_ready_i,
  input  wire logic               ext_sync_i,
  input  wire logic               sync_clk_i,
  input  wire fhs_pkg::fhs_sense_t sense_i,
  input  wire logic [2:0]         blocks_i,
  output fhs_pkg::fhs_ctrl_t      ctrl_o,
  output logic [1:0]              uv_count_o,
  output logic [1:0]              oc_count_o
);
  import fhs_pkg::*;

  typedef struct packed {
    fhs_state_t  state;
    logic [1:0]  uv_cnt;
    logic [1:0]  oc_cnt;
    logic [15:0] timer;
    fhs_ctrl_t   ctrl;
  } fhs_seq_st_t;

  fhs_seq_st_t st_reg;
  fhs_seq_st_t st_next;
  logic        tick;
  logic        on_req;
  logic [4:0]  oc_limit;
  logic        oc_over;
  logic        fault;

  fhs_tick_gen #(.DIV(DIV)) u_tick (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .ext_sync_i (ext_sync_i),
    .sync_clk_i (sync_clk_i),
    .tick_o     (tick)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] inc_sat(input logic [1:0] v);
    inc_sat = (v == 2'h3) ? v : v + 2'h1;
  endfunction : inc_sat

  always_comb begin
    on_req   = enable_i & supply_ready_i;
    oc_limit = 5'(OC_STEP_AMPS) * ({2'h0, blocks_i} + 5'h01);
    oc_over  = sense_i.oc_sample > oc_limit;
    fault    = tick && (st_reg.state == FHS_SOFTSTART || st_reg.state == FHS_RUN)
               && ((sense_i.uv_trip && st_reg.uv_cnt == 2'(FAULT_OVF_COUNT - 1))
                   || (oc_over && st_reg.oc_cnt == 2'(FAULT_OVF_COUNT - 1)));
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_next                     = st_reg;
    st_next.ctrl.shutdown_pulse = 1'b0;
    if (st_reg.state == FHS_SOFTSTART || st_reg.state == FHS_RUN) begin
      if (tick) begin
        if (sense_i.uv_trip) st_next.uv_cnt = inc_sat(st_reg.uv_cnt);
        else if (sense_i.uv_recover) st_next.uv_cnt = CNT_RST;
        if (oc_over) st_next.oc_cnt = inc_sat(st_reg.oc_cnt);
        else st_next.oc_cnt = CNT_RST;
      end
    end
    case (st_reg.state)
      FHS_OFF: begin
        st_next.uv_cnt = CNT_RST;
        st_next.oc_cnt = CNT_RST;
        if (on_req) begin
          st_next.state          = FHS_SOFTSTART;
          st_next.timer          = 16'h0000;
          st_next.ctrl.switch_en = 1'b1;
          st_next.ctrl.ss_charge = 1'b1;
        end
      end
      FHS_DISCHARGE: begin
        st_next.timer = st_reg.timer + 16'h0001;
        if (st_reg.timer == 16'(DIS_CYCLES - 1)) begin
          st_next.state             = FHS_OFF;
          st_next.ctrl.ss_discharge = 1'b0;
        end
      end
      FHS_SOFTSTART, FHS_RUN, FHS_COOL: begin
        if (st_reg.state != FHS_COOL && tick) st_next.timer = st_reg.timer + 16'h0001;
        if (st_reg.state == FHS_COOL && tick) st_next.timer = st_reg.timer + 16'h0001;
        if (fault) begin
          st_next.state                  = FHS_COOL;
          st_next.timer                  = 16'h0000;
          st_next.uv_cnt                 = CNT_RST;
          st_next.oc_cnt                 = CNT_RST;
          st_next.ctrl.switch_en         = 1'b0;
          st_next.ctrl.ss_charge         = 1'b0;
          st_next.ctrl.output_valid_flag = 1'b0;
          st_next.ctrl.shutdown_pulse    = 1'b1;
        end else if (st_reg.state == FHS_COOL) begin
          if (tick && st_reg.timer == 16'(SS_CYCLES - 1)) begin
            st_next.state          = FHS_SOFTSTART;
            st_next.timer          = 16'h0000;
            st_next.ctrl.switch_en = 1'b1;
            st_next.ctrl.ss_charge = 1'b1;
          end
        end else if (st_reg.state == FHS_SOFTSTART && tick
                     && st_reg.timer == 16'(SS_CYCLES - 1)) begin
          st_next.state                  = FHS_RUN;
          st_next.ctrl.output_valid_flag = 1'b1;
        end
      end
      default: begin
        st_next = '0;
      end
    endcase
    if (!on_req && st_reg.state != FHS_OFF && st_reg.state != FHS_DISCHARGE) begin
      st_next.state             = FHS_DISCHARGE;
      st_next.timer             = 16'h0000;
      st_next.uv_cnt            = CNT_RST;
      st_next.oc_cnt            = CNT_RST;
      st_next.ctrl              = '0;
      st_next.ctrl.ss_discharge = 1'b1;
    end
    if (!enable_i) st_next.ctrl.output_valid_flag = 1'b0;
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign ctrl_o     = st_reg.ctrl;
  assign uv_count_o = st_reg.uv_cnt;
  assign oc_count_o = st_reg.oc_cnt;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_shutdown;
    ctrl_o.shutdown_pulse;
  endsequence

  a_shutdown_clears: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_shutdown |-> uv_count_o == 2'h0 && oc_count_o == 2'h0)
    else $error("Counters not cleared at shutdown.");
  a_shutdown_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
    s_shutdown |-> !ctrl_o.switch_en && !ctrl_o.output_valid_flag)
    else $error("Switching active after shutdown.");
  a_shutdown_cause: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $rose(ctrl_o.shutdown_pulse) |-> $past(uv_count_o) == 2'h2 || $past(oc_count_o) == 2'h2)
    else $error("Shutdown without counter overflow.");
  a_enable_valid: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !enable_i |=> !ctrl_o.output_valid_flag)
    else $error("Valid flag high while disabled.");
  a_oc_step: assert property (@(posedge clk_i) disable iff (!rstn_i)
    oc_count_o != 2'h0 && !ctrl_o.shutdown_pulse && $past(oc_count_o) != 2'h0
    |-> oc_count_o - $past(oc_count_o) <= 2'h1)
    else $error("Overcurrent counter jumped.");
  a_cool_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    st_reg.state == FHS_COOL && st_reg.timer < 16'(SS_CYCLES - 1) |=> !ctrl_o.switch_en)
    else $error("Switching during cool-down.");
  a_cnt_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !tick && st_reg.state == FHS_RUN && on_req |=> $stable(uv_count_o))
    else $error("Counter moved without tick.");
  a_valid_rise: assert property (@(posedge clk_i) disable iff (!rstn_i)
    $rose(ctrl_o.output_valid_flag) |-> st_reg.state == FHS_RUN && ctrl_o.switch_en)
    else $error("Valid flag without run state.");

endmodule : fhs_sequencer

// [testbench/fhs_sense_model.sv]
/*
  Far-side model: feedback comparator, current sense and external sync clock.
  Assumes the bench sets fault levels at the falling clock edge.
*/
`timescale 1ns/10ps
module fhs_sense_model (
  input  wire logic          clk_i,
  input  wire logic          fb_low_i,
  input  wire logic          fb_band_i,
  input  wire logic [4:0]    amps_i,
  input  wire logic          sync_run_i,
  output fhs_pkg::fhs_sense_t sense_o,
  output logic               sync_clk_o
);
  import fhs_pkg::*;
  logic [2:0] div_reg = 3'h0;
  // Recovery is withheld while the feedback sits inside the hysteresis band.
  assign sense_o = {fb_low_i, ~fb_low_i & ~fb_band_i, amps_i};
  // Sync clock runs at one eighth of clk and stands still when stopped.
  always @(posedge clk_i) begin
    if (sync_run_i) begin
      div_reg <= div_reg + 3'h1;
    end
  end
  assign sync_clk_o = div_reg[2];
endmodule : fhs_sense_model

// [testbench/tb_top.sv]
/*
  Self-checking bench for the fault hiccup sequencer.
  Assumes the sense model on the far side, shortened soft-start and divider counts, and the full 256-cycle discharge count.
*/
`timescale 1ns/10ps
module tb_top;
  import fhs_pkg::*;
  localparam int unsigned SS  = 4;
  localparam int unsigned DV  = 4;
  localparam int unsigned DIS = 256;
  logic       clk_i = 1'b0;
  logic       rstn_i, enable_i, supply_ready_i, ext_sync_i;
  logic       fb_low, fb_band, sync_run, sync_clk;
  logic [4:0] amps;
  logic [2:0] blocks_i;
  logic [1:0] uv_cnt, oc_cnt;
  fhs_sense_t sense;
  fhs_ctrl_t  ctrl;
  int         bad_count = 0;
  int         samples_checked = 0;

  always #2.5 clk_i = ~clk_i;

  fhs_sense_model model_u (.clk_i(clk_i), .fb_low_i(fb_low), .fb_band_i(fb_band), .amps_i(amps),
    .sync_run_i(sync_run), .sense_o(sense), .sync_clk_o(sync_clk));
  fhs_sequencer #(.SS_CYCLES(SS), .DIS_CYCLES(DIS), .DIV(DV)) dut_u (.clk_i(clk_i),
    .rstn_i(rstn_i), .enable_i(enable_i), .supply_ready_i(supply_ready_i),
    .ext_sync_i(ext_sync_i), .sync_clk_i(sync_clk), .sense_i(sense),
    .blocks_i(blocks_i), .ctrl_o(ctrl), .uv_count_o(uv_cnt), .oc_count_o(oc_cnt));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic final_report();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  function automatic logic probe(input int w);
    case (w)
      0: return ctrl.output_valid_flag;
      1: return ctrl.shutdown_pulse;
      2: return ctrl.switch_en;
      3: return uv_cnt == 2'h1;
      4: return oc_cnt == 2'h1;
      default: return ctrl.ss_discharge;
    endcase
  endfunction : probe

  task automatic wait_on(input int w, output int n);
    n = 0;
    while (probe(w) !== 1'b1 && n < 300) begin
      @(negedge clk_i);
      n++;
    end
  endtask : wait_on

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic start_up();
    int n;
    enable_i = 1'b1;
    wait_on(2, n);
    check("start_lat", 16'(n), 16'h0001);
    check("ss_on", 16'(ctrl.ss_charge), 16'h0001);
    wait_on(0, n);
    check("ss_len", 16'(n >= (SS - 1) * DV - 1 && n <= SS * DV + 3), 16'h0001);
  endtask : start_up

  task automatic oc_limits();
    int n;
    for (int b = 0; b < 4; b++) begin
      blocks_i = 3'(b);
      amps = 5'(2 * (b + 1));
      repeat (3 * DV) @(negedge clk_i);
      check("oc_at_lim", 16'(oc_cnt), 16'h0000);
      amps = amps + 5'h01;
      wait_on(4, n);
      check("oc_over", 16'(n <= 2 * DV), 16'h0001);
      amps = 5'h00;
      repeat (2 * DV) @(negedge clk_i);
      check("oc_clear", 16'(oc_cnt), 16'h0000);
    end
  endtask : oc_limits

  task automatic uv_recover();
    int n;
    fb_low = 1'b1;
    wait_on(3, n);
    fb_low = 1'b0;
    fb_band = 1'b1;
    check("uv_inc", 16'(n <= 2 * DV), 16'h0001);
    repeat (3 * DV) @(negedge clk_i);
    check("uv_band", 16'(uv_cnt), 16'h0001);
    fb_band = 1'b0;
    repeat (2 * DV) @(negedge clk_i);
    check("uv_clr", 16'(uv_cnt), 16'h0000);
  endtask : uv_recover

  task automatic ext_sync();
    int n;
    ext_sync_i = 1'b1;
    repeat (2) @(negedge clk_i);
    fb_low = 1'b1;
    repeat (6 * DV) @(negedge clk_i);
    check("sync_hold", 16'(uv_cnt), 16'h0000);
    sync_run = 1'b1;
    wait_on(3, n);
    fb_low = 1'b0;
    check("sync_tick", 16'(n <= 20), 16'h0001);
    repeat (24) @(negedge clk_i);
    sync_run = 1'b0;
    ext_sync_i = 1'b0;
    check("sync_clr", 16'(uv_cnt), 16'h0000);
  endtask : ext_sync

  task automatic hiccup(input bit oc);
    int n;
    blocks_i = 3'h2;
    if (oc) amps = 5'h07;
    else fb_low = 1'b1;
    wait_on(oc ? 4 : 3, n);
    wait_on(1, n);
    check("trip_gap", 16'(n), 16'(2 * DV));
    check("off_trip", 16'(ctrl.switch_en), 16'h0000);
    check("ss_off", 16'(ctrl.ss_charge), 16'h0000);
    @(negedge clk_i);
    check("cnt_clr", 16'(oc ? oc_cnt : uv_cnt), 16'h0000);
    wait_on(2, n);
    check("cool_len", 16'(n >= (SS - 1) * DV - 1 && n <= SS * DV + 3), 16'h0001);
    wait_on(1, n);
    check("rehiccup", 16'(n <= 4 * DV && !ctrl.output_valid_flag), 16'h0001);
    amps = 5'h00;
    fb_low = 1'b0;
    wait_on(0, n);
    check("restart", 16'(n < 300), 16'h0001);
  endtask : hiccup

  task automatic shut_off();
    int n;
    enable_i = 1'b0;
    @(negedge clk_i);
    check("valid_drop", 16'(ctrl.output_valid_flag), 16'h0000);
    wait_on(5, n);
    n = 0;
    while (ctrl.ss_discharge === 1'b1 && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    check("dis_len", 16'(n), 16'(DIS));
    check("dis_off", 16'(ctrl.switch_en), 16'h0000);
  endtask : shut_off

  task automatic supply_loss();
    int n;
    enable_i = 1'b1;
    wait_on(0, n);
    check("re_start", 16'(n < 300), 16'h0001);
    supply_ready_i = 1'b0;
    @(negedge clk_i);
    supply_ready_i = 1'b1;
    check("sup_dis", 16'({ctrl.ss_discharge, ctrl.switch_en, ctrl.output_valid_flag}),
          16'h0004);
    n = 0;
    while (ctrl.ss_discharge === 1'b1 && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    check("sup_len", 16'(n), 16'(DIS));
    @(negedge clk_i);
    check("sup_back", 16'(ctrl.switch_en), 16'h0001);
  endtask : supply_loss

  initial begin
    rstn_i = 1'b0;
    enable_i = 1'b0;
    supply_ready_i = 1'b1;
    ext_sync_i = 1'b0;
    fb_low = 1'b0;
    fb_band = 1'b0;
    amps = 5'h00;
    sync_run = 1'b0;
    blocks_i = 3'h0;
    repeat (4) @(negedge clk_i);
    check("rst_out", 16'({ctrl, uv_cnt, oc_cnt}), 16'h0000);
    rstn_i = 1'b1;
    @(negedge clk_i);
    start_up();
    oc_limits();
    uv_recover();
    ext_sync();
    hiccup(1'b0);
    hiccup(1'b1);
    shut_off();
    supply_loss();
    final_report();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    final_report();
  end
endmodule : tb_top
